// >>> logic/drs_defines.vh
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH

`define DRS_IDX_RMS_WINDOW    16'h2114
`define DRS_IDX_RMS_CURRENT   16'h2115
`define DRS_IDX_UPTIME        16'h2141
`define DRS_IDX_REF_LEVEL     16'h2200
`define DRS_IDX_BUS_VOLT      16'h2201
`define DRS_IDX_TEMP          16'h2202
`define DRS_IDX_WIND_A        16'h2203
`define DRS_IDX_WIND_B        16'h2204
`define DRS_IDX_SINE          16'h2205
`define DRS_IDX_COSINE        16'h2206
`define DRS_IDX_CONV_OFFSET   16'h2207
`define DRS_IDX_OFFSET_A      16'h2210
`define DRS_IDX_OFFSET_B      16'h2211
`define DRS_IDX_STAT_CUR_X    16'h2212
`define DRS_IDX_STAT_CUR_Y    16'h2213
`define DRS_IDX_STAT_VOLT_X   16'h221a
`define DRS_IDX_STAT_VOLT_Y   16'h221b
`define DRS_IDX_ANGLE         16'h2260
`define DRS_IDX_HALL          16'h2261
`define DRS_IDX_ANGLE_WR      16'h2262

`define DRS_RST_WINDOW        16'h0000
`define DRS_RST_ANGLE         16'h0000
`define DRS_ANGLE_MAX         16'h0168
`define DRS_RMS_CLIP          16'h7fff
`define DRS_CAL_SHIFT         4
`define DRS_CAL_LAST          5'h0f
`define DRS_RMS_CNT_MAX       17'h10000
`define DRS_DIV_STEPS         6'h32
`define DRS_CLK_NS            10
`define DRS_MS_NS             1000000
`define DRS_MS_CYCLES         (`DRS_MS_NS / `DRS_CLK_NS)

`endif

// >>> logic/drs_hall_map.v
`timescale 1ns/100ps
`default_nettype none
module drs_hall_map
(
    input  wire       clock_i,
    input  wire       reset_n_i,
    input  wire [2:0] hall_i,
    input  wire [5:0] sel_i,
    input  wire [2:0] inv_i,
    output reg  [2:0] hall_o
);
    genvar g;

    // Each reported line picks its source line and may be inverted.
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : line
            wire [1:0] src = sel_i[2*g+1:2*g];
            wire       pick = (src == 2'h2) ? hall_i[2] :
                              (src == 2'h1) ? hall_i[1] : hall_i[0];
            always @(posedge clock_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    hall_o[g] <= 1'b0;
                else
                    hall_o[g] <= pick ^ inv_i[g];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> logic/drs_sqrt.v
`timescale 1ns/100ps
`default_nettype none
module drs_sqrt
(
    input  wire        clock_i,
    input  wire        reset_n_i,
    input  wire        start_i,
    input  wire [33:0] radicand_i,
    output reg  [16:0] root_o,
    output reg         done_o
);
    reg [33:0] op;
    reg [33:0] res;
    reg [33:0] one;
    reg        run;

    wire [33:0] trial = res + one;

    // Bit-pair square root, one result bit per cycle, 17 cycles in all.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            op     <= 34'h0;
            res    <= 34'h0;
            one    <= 34'h0;
            run    <= 1'b0;
            root_o <= 17'h0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                op  <= radicand_i;
                res <= 34'h0;
                one <= 34'h100000000;
                run <= 1'b1;
            end
            else if (run)
            begin
                if (op >= trial)
                begin
                    op  <= op - trial;
                    res <= (res >> 1) + one;
                end
                else
                    res <= res >> 1;
                one <= one >> 2;
                if (one == 34'h1)
                begin
                    run    <= 1'b0;
                    done_o <= 1'b1;
                    root_o <= (op >= trial) ? res[17:1] + one[16:0] : res[17:1];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/drs_status_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "drs_defines.vh"
module drs_status_bank
#(
    parameter MS_CYCLES = `DRS_MS_CYCLES
)
(
    input  wire        clock_i,
    input  wire        reset_n_i,
    input  wire        obj_req_i,
    input  wire        obj_wr_i,
    input  wire [15:0] obj_index_i,
    input  wire [31:0] obj_wdata_i,
    input  wire        cl_tick_i,
    input  wire [15:0] ref_level_i,
    input  wire [15:0] bus_volt_i,
    input  wire [15:0] temp_i,
    input  wire [15:0] wind_a_raw_i,
    input  wire [15:0] wind_b_raw_i,
    input  wire [15:0] sine_i,
    input  wire [15:0] cosine_i,
    input  wire [15:0] conv_offset_i,
    input  wire [15:0] stat_cur_x_i,
    input  wire [15:0] stat_cur_y_i,
    input  wire [15:0] stat_volt_x_i,
    input  wire [15:0] stat_volt_y_i,
    input  wire [15:0] comm_angle_i,
    input  wire        microstep_i,
    input  wire [2:0]  hall_pins_i,
    input  wire [5:0]  hall_sel_i,
    input  wire [2:0]  hall_inv_i,
    output reg         obj_ack_o,
    output reg         obj_err_o,
    output reg  [31:0] obj_rdata_o,
    output reg  [15:0] wind_a_o,
    output reg  [15:0] wind_b_o,
    output reg  [15:0] step_angle_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DIV  = 3'b010;
    localparam ST_SQRT = 3'b100;

    reg  [2:0]  hall_meta;
    reg  [2:0]  hall_sync;
    wire [2:0]  hall_state;
    reg  [31:0] ms_div;
    reg         ms_tick;
    reg  [31:0] uptime;
    reg  [4:0]  cal_cnt;
    reg  [19:0] cal_sum_a;
    reg  [19:0] cal_sum_b;
    reg         cal_done;
    reg  [15:0] off_a;
    reg  [15:0] off_b;
    reg  [15:0] win_len;
    reg  [15:0] win_ms;
    reg  [15:0] angle_wr;
    reg  [49:0] acc;
    reg  [16:0] acc_cnt;
    reg  [16:0] snap_cnt;
    reg  [49:0] dvd;
    reg  [17:0] rem;
    reg  [5:0]  div_cnt;
    reg  [2:0]  state;
    reg         sq_start;
    reg  [15:0] rms_value;
    reg         rms_pend;
    reg         rd_armed;
    wire [16:0] root;
    wire        root_done;

    wire        win_mode = ~win_len[15] & (win_len != 16'h0000);
    wire        st_idle  = state[0];
    wire        take     = obj_req_i & ~rms_pend;
    wire        close_win = win_mode & ms_tick & (win_ms == win_len - 16'h0001);
    wire        close_rd = rd_armed & st_idle;
    wire        close    = close_win | close_rd;
    wire        wr_ok    = take & obj_wr_i;
    wire [19:0] next_cal_a = cal_sum_a + {{4{wind_a_raw_i[15]}}, wind_a_raw_i};
    wire [19:0] next_cal_b = cal_sum_b + {{4{wind_b_raw_i[15]}}, wind_b_raw_i};
    wire [31:0] sq_a = $signed(wind_a_o) * $signed(wind_a_o);
    wire [31:0] sq_b = $signed(wind_b_o) * $signed(wind_b_o);
    wire [32:0] sq_sum = {1'b0, sq_a} + {1'b0, sq_b};
    wire [17:0] next_rem = {rem[16:0], dvd[49]};

    // Hall pins come from outside and pass two flip-flops first.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            hall_meta <= 3'h0;
            hall_sync <= 3'h0;
        end
        else
        begin
            hall_meta <= hall_pins_i;
            hall_sync <= hall_meta;
        end
    end

    drs_hall_map u_hall
    (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .hall_i    (hall_sync),
        .sel_i     (hall_sel_i),
        .inv_i     (hall_inv_i),
        .hall_o    (hall_state)
    );

    // Millisecond enable and the uptime count; the count wraps after 2^32 ms.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ms_div  <= 32'h0;
            ms_tick <= 1'b0;
            uptime  <= 32'h0;
        end
        else
        begin
            ms_tick <= 1'b0;
            if (ms_div == MS_CYCLES - 1)
            begin
                ms_div  <= 32'h0;
                ms_tick <= 1'b1;
                uptime  <= uptime + 32'h1;
            end
            else
                ms_div <= ms_div + 32'h1;
        end
    end

    // Startup calibration averages sixteen loop samples per winding.
    // A master write to an offset ends calibration so the write is not lost.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cal_cnt   <= 5'h0;
            cal_sum_a <= 20'h0;
            cal_sum_b <= 20'h0;
            cal_done  <= 1'b0;
            off_a     <= 16'h0;
            off_b     <= 16'h0;
        end
        else if (wr_ok && obj_index_i == `DRS_IDX_OFFSET_A)
        begin
            off_a    <= obj_wdata_i[15:0];
            cal_done <= 1'b1;
        end
        else if (wr_ok && obj_index_i == `DRS_IDX_OFFSET_B)
        begin
            off_b    <= obj_wdata_i[15:0];
            cal_done <= 1'b1;
        end
        else if (cl_tick_i && !cal_done)
        begin
            cal_sum_a <= next_cal_a;
            cal_sum_b <= next_cal_b;
            cal_cnt   <= cal_cnt + 5'h1;
            if (cal_cnt == `DRS_CAL_LAST)
            begin
                cal_done <= 1'b1;
                off_a    <= next_cal_a[`DRS_CAL_SHIFT+15:`DRS_CAL_SHIFT];
                off_b    <= next_cal_b[`DRS_CAL_SHIFT+15:`DRS_CAL_SHIFT];
            end
        end
    end

    // Offset-corrected winding currents feed the RMS path and the outputs.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wind_a_o <= 16'h0;
            wind_b_o <= 16'h0;
        end
        else
        begin
            wind_a_o <= wind_a_raw_i - off_a;
            wind_b_o <= wind_b_raw_i - off_b;
        end
    end

    // Window length and the writable angle copy.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            win_len  <= `DRS_RST_WINDOW;
            angle_wr <= `DRS_RST_ANGLE;
        end
        else if (wr_ok)
        begin
            if (obj_index_i == `DRS_IDX_RMS_WINDOW)
                win_len <= obj_wdata_i[15:0];
            if ((obj_index_i == `DRS_IDX_ANGLE_WR || obj_index_i == `DRS_IDX_ANGLE) &&
                obj_wdata_i[15:0] <= `DRS_ANGLE_MAX)
                angle_wr <= obj_wdata_i[15:0];
        end
    end

    // The written angle reaches the motor only in micro-stepping mode.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            step_angle_o <= `DRS_RST_ANGLE;
        else
            step_angle_o <= microstep_i ? angle_wr : comm_angle_i;
    end

    // Square-sum accumulation per current-loop period. The count saturates
    // at 65536 periods, so a longer interval reports the first 65536 only.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            acc      <= 50'h0;
            acc_cnt  <= 17'h0;
            win_ms   <= 16'h0;
            snap_cnt <= 17'h0;
        end
        else
        begin
            if (close && st_idle)
            begin
                snap_cnt <= acc_cnt;
                acc      <= cl_tick_i ? {17'h0, sq_sum} : 50'h0;
                acc_cnt  <= cl_tick_i ? 17'h1 : 17'h0;
            end
            else if (cl_tick_i && acc_cnt != `DRS_RMS_CNT_MAX)
            begin
                acc     <= acc + {17'h0, sq_sum};
                acc_cnt <= acc_cnt + 17'h1;
            end
            if (close_win || (wr_ok && obj_index_i == `DRS_IDX_RMS_WINDOW))
                win_ms <= 16'h0;
            else if (ms_tick && win_mode)
                win_ms <= win_ms + 16'h1;
        end
    end

    // Divide the interval sum by its sample count, then take the root.
    // An empty interval reports zero without running the divider.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state     <= ST_IDLE;
            dvd       <= 50'h0;
            rem       <= 18'h0;
            div_cnt   <= 6'h0;
            sq_start  <= 1'b0;
            rms_value <= 16'h0;
        end
        else
        begin
            sq_start <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (close)
                    begin
                        if (acc_cnt == 17'h0)
                            rms_value <= 16'h0;
                        else
                        begin
                            dvd     <= acc;
                            rem     <= 18'h0;
                            div_cnt <= 6'h0;
                            state   <= ST_DIV;
                        end
                    end
                end
                ST_DIV:
                begin
                    if (next_rem >= {1'b0, snap_cnt})
                    begin
                        rem <= next_rem - {1'b0, snap_cnt};
                        dvd <= {dvd[48:0], 1'b1};
                    end
                    else
                    begin
                        rem <= next_rem;
                        dvd <= {dvd[48:0], 1'b0};
                    end
                    div_cnt <= div_cnt + 6'h1;
                    if (div_cnt == `DRS_DIV_STEPS - 6'h1)
                    begin
                        sq_start <= 1'b1;
                        state    <= ST_SQRT;
                    end
                end
                ST_SQRT:
                begin
                    if (root_done)
                    begin
                        rms_value <= root[16:15] != 2'h0 ? `DRS_RMS_CLIP : root[15:0];
                        state     <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    drs_sqrt u_sqrt
    (
        .clock_i    (clock_i),
        .reset_n_i  (reset_n_i),
        .start_i    (sq_start),
        .radicand_i (dvd[33:0]),
        .root_o     (root),
        .done_o     (root_done)
    );

    // Object access: one request per ack. A zero-window RMS read closes the
    // interval and answers only once the new result exists; requests that
    // arrive meanwhile are ignored.
    always @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            obj_ack_o   <= 1'b0;
            obj_err_o   <= 1'b0;
            obj_rdata_o <= 32'h0;
            rms_pend    <= 1'b0;
            rd_armed    <= 1'b0;
        end
        else
        begin
            obj_ack_o <= 1'b0;
            obj_err_o <= 1'b0;
            if (close_rd)
                rd_armed <= 1'b0;
            if (rms_pend && !rd_armed && st_idle && !close_rd)
            begin
                rms_pend    <= 1'b0;
                obj_ack_o   <= 1'b1;
                obj_rdata_o <= {16'h0, rms_value};
            end
            else if (take)
            begin
                obj_ack_o   <= 1'b1;
                obj_rdata_o <= 32'h0;
                if (obj_wr_i)
                begin
                    case (obj_index_i)
                        `DRS_IDX_RMS_WINDOW, `DRS_IDX_OFFSET_A, `DRS_IDX_OFFSET_B:
                            obj_err_o <= 1'b0;
                        `DRS_IDX_ANGLE, `DRS_IDX_ANGLE_WR:
                            obj_err_o <= obj_wdata_i[15:0] > `DRS_ANGLE_MAX;
                        default:
                            obj_err_o <= 1'b1;
                    endcase
                end
                else
                begin
                    case (obj_index_i)
                        `DRS_IDX_RMS_WINDOW:  obj_rdata_o <= {16'h0, win_len};
                        `DRS_IDX_RMS_CURRENT:
                        begin
                            if (win_mode)
                                obj_rdata_o <= {16'h0, rms_value};
                            else
                            begin
                                // Read data must hold until the delayed answer.
                                obj_rdata_o <= obj_rdata_o;
                                obj_ack_o <= 1'b0;
                                rms_pend  <= 1'b1;
                                rd_armed  <= 1'b1;
                            end
                        end
                        `DRS_IDX_UPTIME:      obj_rdata_o <= uptime;
                        `DRS_IDX_REF_LEVEL:   obj_rdata_o <= {16'h0, ref_level_i};
                        `DRS_IDX_BUS_VOLT:    obj_rdata_o <= {16'h0, bus_volt_i};
                        `DRS_IDX_TEMP:        obj_rdata_o <= {16'h0, temp_i};
                        `DRS_IDX_WIND_A:      obj_rdata_o <= {16'h0, wind_a_o};
                        `DRS_IDX_WIND_B:      obj_rdata_o <= {16'h0, wind_b_o};
                        `DRS_IDX_SINE:        obj_rdata_o <= {16'h0, sine_i};
                        `DRS_IDX_COSINE:      obj_rdata_o <= {16'h0, cosine_i};
                        `DRS_IDX_CONV_OFFSET: obj_rdata_o <= {16'h0, conv_offset_i};
                        `DRS_IDX_OFFSET_A:    obj_rdata_o <= {16'h0, off_a};
                        `DRS_IDX_OFFSET_B:    obj_rdata_o <= {16'h0, off_b};
                        `DRS_IDX_STAT_CUR_X:  obj_rdata_o <= {16'h0, stat_cur_x_i};
                        `DRS_IDX_STAT_CUR_Y:  obj_rdata_o <= {16'h0, stat_cur_y_i};
                        `DRS_IDX_STAT_VOLT_X: obj_rdata_o <= {16'h0, stat_volt_x_i};
                        `DRS_IDX_STAT_VOLT_Y: obj_rdata_o <= {16'h0, stat_volt_y_i};
                        `DRS_IDX_ANGLE:       obj_rdata_o <= {16'h0, comm_angle_i};
                        `DRS_IDX_HALL:        obj_rdata_o <= {29'h0, hall_state};
                        `DRS_IDX_ANGLE_WR:    obj_rdata_o <= {16'h0, angle_wr};
                        default:              obj_err_o <= 1'b1;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/drs_status_bank_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module drs_status_bank_chk
(
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        obj_req_i,
    input wire logic        obj_wr_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [31:0] obj_wdata_i,
    input wire logic [15:0] bus_volt_i,
    input wire logic [15:0] comm_angle_i,
    input wire logic        microstep_i,
    input wire logic        obj_ack_o,
    input wire logic        obj_err_o,
    input wire logic [31:0] obj_rdata_o,
    input wire logic [15:0] step_angle_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // Read-only places; a write there must be refused without effect.
    logic        ro;
    logic [15:0] wd16;
    assign ro = obj_index_i inside {16'h2115, 16'h2141, 16'h2200, 16'h2201, 16'h2202,
        16'h2203, 16'h2204, 16'h2205, 16'h2206, 16'h2207, 16'h2212, 16'h2213,
        16'h221a, 16'h221b, 16'h2261};
    assign wd16 = obj_wdata_i[15:0];

    a_quick_ack: assert property (obj_req_i && obj_index_i != 16'h2115 |=> obj_ack_o)
        else $error("access not answered in one cycle");
    a_ack_single: assert property (obj_ack_o && !obj_req_i |=> !obj_ack_o)
        else $error("answer strobe longer than one cycle");
    a_err_with_ack: assert property (obj_err_o |-> obj_ack_o)
        else $error("refusal without answer");
    a_ro_refused: assert property (obj_req_i && obj_wr_i && ro |=> obj_ack_o && obj_err_o)
        else $error("write to read-only place accepted");
    a_bus_read: assert property (obj_req_i && !obj_wr_i && obj_index_i == 16'h2201
        |=> obj_rdata_o == {16'h0000, $past(bus_volt_i)})
        else $error("bus voltage read wrong");
    a_angle_limit: assert property (obj_req_i && obj_wr_i && obj_index_i == 16'h2262
        |=> obj_err_o == ($past(wd16) > 16'h0168))
        else $error("angle range check wrong");
    a_hall_bits: assert property (obj_req_i && !obj_wr_i && obj_index_i == 16'h2261
        |=> obj_rdata_o[31:3] == 29'h0)
        else $error("hall state uses upper bits");
    a_step_mode: assert property (!microstep_i |=> step_angle_o == $past(comm_angle_i))
        else $error("angle copy used outside micro-stepping");
    a_rdata_hold: assert property (!obj_ack_o |-> $stable(obj_rdata_o))
        else $error("read data changed without answer");

    c_rms_read: cover property (obj_req_i && obj_index_i == 16'h2115 ##[2:200] obj_ack_o);
    c_refused: cover property (obj_ack_o && obj_err_o);
    c_microstep: cover property (microstep_i && step_angle_o != comm_angle_i);
endmodule

bind drs_status_bank drs_status_bank_chk u_chk
(
    .clock_i(clock_i), .reset_n_i(reset_n_i), .obj_req_i(obj_req_i),
    .obj_wr_i(obj_wr_i), .obj_index_i(obj_index_i), .obj_wdata_i(obj_wdata_i),
    .bus_volt_i(bus_volt_i), .comm_angle_i(comm_angle_i), .microstep_i(microstep_i),
    .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o), .obj_rdata_o(obj_rdata_o),
    .step_angle_o(step_angle_o)
);
`default_nettype wire

// >>> tb/drs_master.sv
`timescale 1ns/100ps
`default_nettype none
module drs_master
(
    input  wire logic        clock_i,
    output var  logic        req_o,
    output var  logic        wr_o,
    output var  logic [15:0] index_o,
    output var  logic [31:0] wdata_o,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    input  wire logic [31:0] rdata_i
);
    initial
    begin
        req_o = 1'b0;
        wr_o = 1'b0;
        index_o = 16'h0000;
        wdata_o = 32'h0000_0000;
    end

    // One object access; the request is a one-cycle pulse, the qualifiers stay
    // until the answer edge, then turn to junk so stale values are never reused.
    task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d,
                          output logic [31:0] rd, output logic er);
        int n;
        rd = 'x;
        er = 1'bx;
        @(negedge clock_i);
        req_o = 1'b1;
        wr_o = w;
        index_o = i;
        wdata_o = d;
        @(negedge clock_i);
        req_o = 1'b0;
        // Bounded wait; callers reread the RMS value well inside the loop limit.
        for (n = 0; n < 400; n++)
        begin
            @(posedge clock_i);
            if (ack_i === 1'b1)
            begin
                rd = rdata_i;
                er = err_i;
                n = 400;
            end
        end
        @(negedge clock_i);
        wr_o = ~w;
        index_o = ~i;
        wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// >>> tb/drs_status_bank_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module drs_status_bank_tb_top;
    logic        clock_i, reset_n_i, tick, mstep, req, wr, ack, err, er;
    logic [15:0] lv [0:10];
    logic [15:0] ra, rb, idx, wa, wb, step;
    logic [2:0]  pins, inv;
    logic [5:0]  sel;
    logic [31:0] wd, rdata, rd;
    int          num_errors, cmp_count;
    localparam logic [15:0] IX [0:10] = '{16'h2200, 16'h2201, 16'h2202, 16'h2205,
        16'h2206, 16'h2207, 16'h2212, 16'h2213, 16'h221a, 16'h221b, 16'h2260};

    drs_status_bank #(.MS_CYCLES(20)) DUT
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .obj_req_i(req), .obj_wr_i(wr),
        .obj_index_i(idx), .obj_wdata_i(wd), .cl_tick_i(tick), .ref_level_i(lv[0]),
        .bus_volt_i(lv[1]), .temp_i(lv[2]), .wind_a_raw_i(ra), .wind_b_raw_i(rb),
        .sine_i(lv[3]), .cosine_i(lv[4]), .conv_offset_i(lv[5]), .stat_cur_x_i(lv[6]),
        .stat_cur_y_i(lv[7]), .stat_volt_x_i(lv[8]), .stat_volt_y_i(lv[9]),
        .comm_angle_i(lv[10]), .microstep_i(mstep), .hall_pins_i(pins),
        .hall_sel_i(sel), .hall_inv_i(inv), .obj_ack_o(ack), .obj_err_o(err),
        .obj_rdata_o(rdata), .wind_a_o(wa), .wind_b_o(wb), .step_angle_o(step)
    );
    drs_master u_master
    (
        .clock_i(clock_i), .req_o(req), .wr_o(wr), .index_o(idx), .wdata_o(wd),
        .ack_i(ack), .err_i(err), .rdata_i(rdata)
    );

    // Free-running 100 MHz clock.
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // One bit wider than the data so that the refusal flag is compared too.
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d);
        u_master.access(w, i, d, rd, er);
    endtask

    // Current-loop strobes every second cycle.
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge clock_i);
            tick = 1'b1;
            @(negedge clock_i);
            tick = 1'b0;
        end
    endtask

    // Startup offsets come from the first strobes and then correct each reading.
    task automatic t_cal;
        ticks(16);
        acc(0, 16'h2210, 0); chk(rd, 32'h0000_0064);
        acc(0, 16'h2211, 0); chk(rd, 32'h0000_ff9c);
        ra = 16'h0067;
        rb = 16'hffa0;
        repeat (2) @(negedge clock_i);
        chk({wa, wb}, {16'h0003, 16'h0004});
        acc(0, 16'h2203, 0); chk(rd, 32'h0000_0003);
        acc(0, 16'h2204, 0); chk(rd, 32'h0000_0004);
        acc(1, 16'h2210, 32'h0000_0065); chk(er, 1'b0);
        acc(0, 16'h2210, 0); chk(rd, 32'h0000_0065);
        chk(wa, 16'h0002);
        acc(1, 16'h2210, 32'h0000_0064);
    endtask

    // Live values read back as they stand; read-only and unmapped places refuse.
    task automatic t_live;
        for (int k = 0; k < 11; k++)
        begin
            acc(0, IX[k], 0);
            chk({er, rd}, {1'b0, 16'h0000, lv[k]});
        end
        acc(1, 16'h2201, 32'h0000_1234); chk(er, 1'b1);
        acc(0, 16'h2202, 0); chk(rd, {16'h0000, lv[2]});
        acc(0, 16'h2300, 0); chk({er, rd}, {1'b1, 32'h0});
    endtask

    // The writable copy accepts 360 but not 361 and steers only micro-stepping.
    task automatic t_angle;
        acc(1, 16'h2262, 32'h0000_0168); chk(er, 1'b0);
        acc(1, 16'h2262, 32'h0000_0169); chk(er, 1'b1);
        acc(0, 16'h2262, 0); chk(rd, 32'h0000_0168);
        mstep = 1'b1;
        repeat (2) @(negedge clock_i);
        chk(step, 16'h0168);
        mstep = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(step, lv[10]);
    endtask

    // Reordered and inverted lines; the pins pass a synchroniser first.
    task automatic t_hall;
        sel = 6'b00_01_10;
        inv = 3'b010;
        pins = 3'b011;
        repeat (6) @(negedge clock_i);
        acc(0, 16'h2261, 0); chk(rd, 32'h0000_0004);
        sel = 6'b11_10_01;
        inv = 3'b101;
        pins = 3'b100;
        repeat (6) @(negedge clock_i);
        acc(0, 16'h2261, 0); chk(rd, 32'h0000_0007);
    endtask

    // Zero window: read-triggered interval; then a 1 ms window with new levels.
    task automatic t_rms;
        acc(1, 16'h2114, 0); chk(er, 1'b0);
        acc(0, 16'h2115, 0);
        ticks(20);
        acc(0, 16'h2115, 0); chk(rd, 32'h0000_0005);
        ra = 16'h006a;
        rb = 16'hffa4;
        acc(1, 16'h2114, 32'h0000_0001);
        acc(0, 16'h2114, 0); chk(rd, 32'h0000_0001);
        ticks(100);
        acc(0, 16'h2115, 0); chk(rd, 32'h0000_000a);
    endtask

    // Each access spends three cycles before its taking edge is repeated, so the
    // two taking edges lie 200 cycles apart: exactly ten counts at 20 per ms.
    task automatic t_uptime;
        logic [31:0] u0;
        acc(0, 16'h2141, 0);
        u0 = rd;
        repeat (197) @(negedge clock_i);
        acc(0, 16'h2141, 0); chk(rd - u0, 32'd10);
    endtask

    task automatic results;
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence; calibration must see the first strobes after reset.
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        reset_n_i = 1'b0;
        tick = 1'b0;
        mstep = 1'b0;
        ra = 16'h0064;
        rb = 16'hff9c;
        pins = 3'b000;
        sel = 6'b10_01_00;
        inv = 3'b000;
        for (int k = 0; k < 10; k++)
            lv[k] = 16'h8000 | 16'(k * 16'h0101);
        lv[10] = 16'h00b4;
        repeat (5) @(negedge clock_i);
        reset_n_i = 1'b1;
        t_cal();
        t_live();
        t_angle();
        t_hall();
        t_rms();
        t_uptime();
        results();
    end

    // The run needs under 3000 cycles; this limit leaves a wide margin.
    initial
    begin
        #500000;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
